// ---- cvsl_defs.svh ----
`ifndef CVSL_DEFS_SVH
`define CVSL_DEFS_SVH
`define CVSL_CUBE_FACES 6
`define CVSL_ALIGN_W_BC 4
`define CVSL_ALIGN_H_BC 4
`define CVSL_ALIGN_W_CMP 8
`define CVSL_ALIGN_H_CMP 4
`define CVSL_ALIGN_W_STD 4
`define CVSL_ALIGN_H_STD 2
`define CVSL_ALIGN_H_STENCIL 4
`define CVSL_ROWS_CMP 4
`endif

// ---- cvsl_pkg.sv ----
package cvsl_pkg;
   typedef enum logic [1:0] {CVSL_FMT_STD, CVSL_FMT_BC, CVSL_FMT_CMP, CVSL_FMT_STENCIL} cvsl_fmt_e;
   typedef enum {CVSL_IDLE, CVSL_WALK, CVSL_ADDR, CVSL_DONE} cvsl_state_e;
endpackage

// ---- cvsl_align.sv ----
`include "cvsl_defs.svh"
module cvsl_align
   import cvsl_pkg::*;
(
   // Format
   input wire cvsl_fmt_e fmt,
   // Units
   output logic [3:0] unit_w,
   output logic [3:0] unit_h,
   output logic [2:0] rows_per_mem
);
   always_comb begin
      unit_w = 4'(`CVSL_ALIGN_W_STD); // [RL22]
      unit_h = 4'(`CVSL_ALIGN_H_STD);
      rows_per_mem = 3'h1;
      unique case (fmt)
         CVSL_FMT_BC: begin
            unit_w = 4'(`CVSL_ALIGN_W_BC);
            unit_h = 4'(`CVSL_ALIGN_H_BC);
         end
         CVSL_FMT_CMP: begin
            unit_w = 4'(`CVSL_ALIGN_W_CMP);
            unit_h = 4'(`CVSL_ALIGN_H_CMP);
            rows_per_mem = 3'(`CVSL_ROWS_CMP);
         end
         CVSL_FMT_STENCIL: unit_h = 4'(`CVSL_ALIGN_H_STENCIL);
         CVSL_FMT_STD: ;
      endcase
   end
endmodule

// ---- cvsl_layout.sv ----
`include "cvsl_defs.svh"
// Summary of operation
// [RL1] A cube is a two-dimensional array of exactly six slices.
// [RL2] Face index 0..5 maps to +X,-X,+Y,-Y,+Z,-Z.
// [RL3] Cube layout never depends on mip count or enabled faces.
// [RL4] Software gives all six faces one format; one format input serves them.
// [RL5] Level sizes are base shifted by level, never below one.
// [RL6] Width and height round up to the alignment unit.
// [RL7] Depth is never rounded to alignment.
// [RL8] Level zero planes stack vertically at x zero.
// [RL9] Level L planes sit 2^L wide below all earlier levels.
// [RL10] Plane base plus in-plane coordinate gives the texel position.
// [RL11] Software picks a pitch wide enough for the widest plane row.
// [RL12] Texels outside the surface never affect the result.
// [RL13] A fetch touching an unmapped page raises a translation error.
// [RL14] Software maps the surface extended to alignment units.
// [RL15] Software pads buffers to 256 elements plus 16 bytes.
// [RL16] Software reserves two extra rows below cube surfaces.
// [RL17] Compressed padding reaches eight rows; alignment stays four.
// [RL18] YUV, 96 and 48 bpt surfaces get a row plus 16 bytes more; the page model pads only YUV surfaces.
// [RL19] Out-of-surface data-port pixels are never returned.
// [RL20] Software adds one row under odd-height render surfaces.
// [RL21] Field-mode surfaces are padded to a multiple of four rows.
// [RL22] Alignment units depend on the format family.
// [RL23] Address is base plus row times pitch over t plus column terms.
// [RL24] Translation errors are sticky, observable, clearable, with the address.
module cvsl_layout
   import cvsl_pkg::*;
#(
   parameter int DIM_W = 14,
   parameter int LVL_W = 4,
   parameter int ADDR_W = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Request
   input wire logic req_valid,
   output logic req_ready,
   input wire logic is_cube,
   input wire cvsl_fmt_e fmt,
   input wire logic [DIM_W-1:0] base_w,
   input wire logic [DIM_W-1:0] base_h,
   input wire logic [DIM_W-1:0] base_d,
   input wire logic [LVL_W-1:0] detail_level,
   input wire logic [DIM_W-1:0] plane,
   input wire logic [DIM_W-1:0] array_slice_stride,
   input wire logic [DIM_W-1:0] tex_x,
   input wire logic [DIM_W-1:0] tex_y,
   input wire logic [ADDR_W-1:0] surf_base,
   input wire logic [ADDR_W-1:0] pitch,
   input wire logic [4:0] bytes_per_texel,
   // Result
   output logic resp_valid,
   output logic [ADDR_W-1:0] resp_addr,
   output logic [DIM_W-1:0] resp_w,
   output logic [DIM_W-1:0] resp_h,
   output logic [DIM_W-1:0] resp_d,
   output logic resp_in_surface,
   // Page check
   input wire logic fetch_valid,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic fetch_page_ok,
   input wire logic fetch_in_surface,
   input wire logic [31:0] fetch_data,
   output logic [31:0] use_data,
   output logic use_valid,
   // Fault status
   output logic xlate_err,
   output logic [ADDR_W-1:0] xlate_err_addr,
   input wire logic xlate_err_clr
);
   typedef struct packed {
      cvsl_state_e state;
      logic [LVL_W-1:0] lvl;
      logic [DIM_W-1:0] y_acc;
      logic [DIM_W-1:0] px;
      logic [DIM_W-1:0] py;
      logic [DIM_W-1:0] lw;
      logic [DIM_W-1:0] lh;
      logic [DIM_W-1:0] ld;
      logic resp_valid;
      logic [ADDR_W-1:0] resp_addr;
      logic in_surf;
      logic use_valid;
      logic [31:0] use_data;
      logic err;
      logic [ADDR_W-1:0] err_addr;
   } cvsl_regs_s;

   cvsl_regs_s r, next_r;
   logic [3:0] unit_w, unit_h;
   logic [2:0] rows_mem;

   cvsl_align u_align (
      .fmt(fmt),
      .unit_w(unit_w),
      .unit_h(unit_h),
      .rows_per_mem(rows_mem)
   );

   function automatic logic [DIM_W-1:0] lvl_dim(input logic [DIM_W-1:0] b,
                                                input logic [LVL_W-1:0] l);
      logic [DIM_W-1:0] s;
      s = b >> l;
      return (s == '0) ? DIM_W'(1) : s; // [RL5]
   endfunction

   function automatic logic [DIM_W-1:0] round_up(input logic [DIM_W-1:0] v,
                                                 input logic [3:0] u);
      return DIM_W'(((v + DIM_W'(u) - DIM_W'(1)) / DIM_W'(u)) * DIM_W'(u)); // [RL6]
   endfunction

   logic [DIM_W-1:0] cur_d, cur_h, per_row, rows_lvl, slice_d, lvl_mask;
   always_comb begin
      cur_d = lvl_dim(base_d, r.lvl); // [RL7]
      cur_h = round_up(lvl_dim(base_h, r.lvl), unit_h);
      per_row = DIM_W'(1) << r.lvl;
      lvl_mask = per_row - DIM_W'(1);
      rows_lvl = (cur_d + lvl_mask) >> r.lvl;
      slice_d = is_cube ? DIM_W'(`CVSL_CUBE_FACES) : lvl_dim(base_d, detail_level); // [RL1]
   end

   always_comb begin
      next_r = r;
      next_r.resp_valid = 1'b0;
      next_r.use_valid = fetch_valid && fetch_in_surface; // [RL12] [RL19]
      next_r.use_data = (fetch_valid && fetch_in_surface) ? fetch_data : r.use_data;
      unique case (r.state)
         CVSL_IDLE: if (req_valid) begin
            next_r.lvl = '0;
            next_r.y_acc = '0;
            next_r.lw = round_up(lvl_dim(base_w, detail_level), unit_w);
            next_r.lh = round_up(lvl_dim(base_h, detail_level), unit_h);
            next_r.ld = slice_d;
            next_r.state = is_cube ? CVSL_ADDR : CVSL_WALK; // [RL3]
            next_r.px = '0;
            next_r.py = is_cube ? DIM_W'(plane * array_slice_stride) : '0; // [RL2]
         end
         CVSL_WALK: begin
            if (r.lvl == detail_level) begin
               next_r.px = DIM_W'((plane & lvl_mask) * r.lw); // [RL8] [RL9]
               next_r.py = DIM_W'(r.y_acc + (plane >> r.lvl) * cur_h);
               next_r.state = CVSL_ADDR;
            end else begin
               next_r.y_acc = DIM_W'(r.y_acc + rows_lvl * cur_h); // [RL9]
               next_r.lvl = r.lvl + LVL_W'(1);
            end
         end
         CVSL_ADDR: begin
            next_r.resp_addr = ADDR_W'(surf_base
               + ((r.py + tex_y) * pitch) / ADDR_W'(rows_mem)
               + (r.px + tex_x) * bytes_per_texel * rows_mem); // [RL10] [RL23]
            next_r.in_surf = (plane < r.ld) && (tex_x < r.lw) && (tex_y < r.lh);
            next_r.state = CVSL_DONE;
         end
         CVSL_DONE: begin
            next_r.resp_valid = 1'b1;
            next_r.state = CVSL_IDLE;
         end
      endcase
      if (xlate_err_clr) next_r.err = 1'b0;
      if (fetch_valid && !fetch_page_ok) begin
         next_r.err = 1'b1; // [RL13] [RL24]
         next_r.err_addr = fetch_addr;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) r <= '0;
      else r <= next_r;
   end

   assign req_ready = (r.state == CVSL_IDLE);
   assign resp_valid = r.resp_valid;
   assign resp_addr = r.resp_addr;
   assign resp_w = r.lw;
   assign resp_h = r.lh;
   assign resp_d = r.ld;
   assign resp_in_surface = r.in_surf;
   assign use_valid = r.use_valid;
   assign use_data = r.use_data;
   assign xlate_err = r.err;
   assign xlate_err_addr = r.err_addr;

   a_err_sets: assert property (@(posedge clk) disable iff (!nrst) // [RL13]
      fetch_valid && !fetch_page_ok |=> xlate_err && xlate_err_addr == $past(fetch_addr))
      else $error("translation error not raised");
   a_err_sticky: assert property (@(posedge clk) disable iff (!nrst) // [RL24]
      xlate_err && !xlate_err_clr |=> xlate_err)
      else $error("translation error lost");
   a_outside_hidden: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
      fetch_valid && !fetch_in_surface |=> !use_valid)
      else $error("outside texel used");
   a_inside_passes: assert property (@(posedge clk) disable iff (!nrst) // [RL19]
      fetch_valid && fetch_in_surface |=> use_valid && use_data == $past(fetch_data))
      else $error("inside texel dropped");
   a_cube_six: assert property (@(posedge clk) disable iff (!nrst) // [RL1]
      req_valid && req_ready && is_cube |-> ##3 resp_valid && resp_d == DIM_W'(6))
      else $error("cube depth not six");
   a_depth_min: assert property (@(posedge clk) disable iff (!nrst) // [RL5]
      resp_valid |-> resp_d != '0)
      else $error("level depth zero");
   a_width_align: assert property (@(posedge clk) disable iff (!nrst) // [RL6]
      resp_valid && fmt == CVSL_FMT_STD |-> resp_w[1:0] == 2'h0 && resp_h[0] == 1'b0)
      else $error("level not aligned");
   a_lvl0_walk: assert property (@(posedge clk) disable iff (!nrst) // [RL8]
      req_valid && req_ready && !is_cube && detail_level == '0 |-> ##4 resp_valid)
      else $error("level zero latency wrong");
   a_outside_keep: assert property (@(posedge clk) disable iff (!nrst) // [RL12]
      fetch_valid && !fetch_in_surface |=> $stable(use_data))
      else $error("outside texel reached data");
   a_err_clears: assert property (@(posedge clk) disable iff (!nrst) // [RL24]
      xlate_err_clr && !(fetch_valid && !fetch_page_ok) |=> !xlate_err)
      else $error("translation error not cleared");
   a_lvl2_walk: assert property (@(posedge clk) disable iff (!nrst) // [RL9]
      req_valid && req_ready && !is_cube && detail_level == LVL_W'(2) |-> ##6 resp_valid)
      else $error("level two latency wrong");

   c_cube: cover property (@(posedge clk) resp_valid && resp_d == DIM_W'(6));
   c_volume: cover property (@(posedge clk) resp_valid && r.lvl > LVL_W'(1));
   c_fault: cover property (@(posedge clk) fetch_valid && !fetch_page_ok);
   c_clear: cover property (@(posedge clk) xlate_err && xlate_err_clr);
endmodule

// ---- cvsl_pt_model.sv ----
module cvsl_pt_model
   import cvsl_pkg::*;
#(
   parameter int ADDR_W = 32,
   parameter logic [31:0] SURF_BASE = 32'h0000_1000,
   parameter int PITCH_BYTES = 256,
   // Six cube slices of twenty rows each
   parameter int ROWS = 120,
   parameter int ALIGN_H = 2,
   parameter bit IS_CUBE = 1'b1,
   parameter bit IS_BC = 1'b0,
   parameter bit IS_YUV = 1'b0,
   parameter bit RENDER = 1'b0,
   parameter bit FIELD_MODE = 1'b0,
   parameter bit IS_BUFFER = 1'b0,
   parameter int BUF_ELEMS = 0,
   parameter int ELEM_BYTES = 4
) (
   // Lookup
   input wire logic [ADDR_W-1:0] fetch_addr,
   output logic fetch_page_ok
);
   timeunit 1ns;
   timeprecision 1ps;
   // Software maps the surface plus every padding row it owes, except the 96 and 48 bpt row
   localparam int ROWS_A = ((ROWS + ALIGN_H - 1) / ALIGN_H) * ALIGN_H;
   localparam int ROWS_B = IS_BC ? ((ROWS_A + 7) / 8) * 8 : ROWS_A;
   localparam int ROWS_C = ROWS_B + (IS_CUBE ? 2 : 0) + (IS_YUV ? 1 : 0);
   localparam int ROWS_D = (RENDER && ROWS_C % 2 == 1) ? ROWS_C + 1 : ROWS_C;
   localparam int ROWS_E = (RENDER && FIELD_MODE) ? ((ROWS_D + 3) / 4) * 4 : ROWS_D;
   localparam int BUF_BYTES = ((BUF_ELEMS + 255) / 256) * 256 * ELEM_BYTES + 16;
   localparam int SURF_BYTES = ROWS_E * PITCH_BYTES + (IS_YUV ? 16 : 0);
   localparam logic [31:0] MAP_END = SURF_BASE + 32'(IS_BUFFER ? BUF_BYTES : SURF_BYTES);
   // Every page below the padded surface end is mapped
   assign fetch_page_ok = (fetch_addr < ADDR_W'(MAP_END));
endmodule

// ---- tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cvsl_pkg::*;
   logic clk = 0, nrst = 0, req_valid = 0, is_cube = 0, fetch_valid = 0, fetch_in_surface = 0;
   logic xlate_err_clr = 0, req_ready, resp_valid, resp_in_surface, fetch_page_ok;
   logic use_valid, xlate_err;
   cvsl_fmt_e fmt = CVSL_FMT_STD;
   logic [13:0] base_w = 0, base_h = 0, base_d = 0, plane = 0, tex_x = 0, tex_y = 0;
   logic [13:0] array_slice_stride = 14'h14, resp_w, resp_h, resp_d;
   logic [3:0] detail_level = 0;
   logic [31:0] surf_base = 32'h1000, pitch = 32'h100, fetch_addr = 0, fetch_data = 0;
   logic [31:0] resp_addr, use_data, xlate_err_addr;
   logic [4:0] bytes_per_texel = 5'h04;
   int bad_count = 0, samples_checked = 0;
   always #4 clk = ~clk;
   cvsl_layout i_dut (
      .clk(clk),
      .nrst(nrst),
      .req_valid(req_valid),
      .req_ready(req_ready),
      .is_cube(is_cube),
      .fmt(fmt),
      .base_w(base_w),
      .base_h(base_h),
      .base_d(base_d),
      .detail_level(detail_level),
      .plane(plane),
      .array_slice_stride(array_slice_stride),
      .tex_x(tex_x),
      .tex_y(tex_y),
      .surf_base(surf_base),
      .pitch(pitch),
      .bytes_per_texel(bytes_per_texel),
      .resp_valid(resp_valid),
      .resp_addr(resp_addr),
      .resp_w(resp_w),
      .resp_h(resp_h),
      .resp_d(resp_d),
      .resp_in_surface(resp_in_surface),
      .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr),
      .fetch_page_ok(fetch_page_ok),
      .fetch_in_surface(fetch_in_surface),
      .fetch_data(fetch_data),
      .use_data(use_data),
      .use_valid(use_valid),
      .xlate_err(xlate_err),
      .xlate_err_addr(xlate_err_addr),
      .xlate_err_clr(xlate_err_clr)
   );
   cvsl_pt_model i_pt (.fetch_addr(fetch_addr), .fetch_page_ok(fetch_page_ok));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out();
      if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // One format for the whole surface, pitch wide enough for every plane row
   task automatic run_req(input logic cube, input cvsl_fmt_e f, input logic [13:0] w, h, d,
                          q, input logic [3:0] l, input logic [13:0] tx, ty);
      int n;
      @(posedge clk);
      is_cube <= cube;
      fmt <= f;
      base_w <= w;
      base_h <= h;
      base_d <= d;
      plane <= q;
      detail_level <= l;
      tex_x <= tx;
      tex_y <= ty;
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         req_valid <= 1'b0;
         #1;
         n++;
      end while (resp_valid !== 1'b1 && n < 40);
      chk("resp_valid", resp_valid, 32'h1);
   endtask
   task automatic fetch(input logic [31:0] a, input logic ins, input logic [31:0] d);
      @(posedge clk);
      fetch_valid <= 1'b1;
      fetch_addr <= a;
      fetch_in_surface <= ins;
      fetch_data <= d;
      @(posedge clk);
      fetch_valid <= 1'b0;
      #1;
   endtask
   task automatic t_cube();
      for (int q = 0; q < 6; q++) begin
         run_req(1'b1, CVSL_FMT_STD, 14'h10, 14'h10, 14'h1, 14'(q), 4'((q % 2) * 2), 14'h3, 14'h2);
         chk("cube_depth", resp_d, 32'h6);
         chk("cube_addr", resp_addr, 32'h1000 + (q * 20 + 2) * 32'h100 + 12);
      end
   endtask
   task automatic t_align();
      logic [13:0] ew [4] = '{14'hC, 14'hC, 14'h10, 14'hC};
      logic [13:0] eh [4] = '{14'h6, 14'h8, 14'h8, 14'h8};
      for (int k = 0; k < 4; k++) begin
         run_req(1'b0, cvsl_fmt_e'(k), 14'hA, 14'h6, 14'h1, 14'h0, 4'h0, 14'h0, 14'h0);
         chk("align_w", resp_w, ew[k]);
         chk("align_h", resp_h, eh[k]);
         chk("align_addr", resp_addr, 32'h1000);
      end
   endtask
   task automatic t_volume();
      int lv [5] = '{0, 1, 2, 3, 1};
      int pq [5] = '{4, 1, 0, 0, 2};
      int ew [5] = '{16, 8, 4, 4, 8};
      int eh [5] = '{10, 6, 2, 2, 6};
      int ed [5] = '{5, 2, 1, 1, 2};
      int ex [5] = '{0, 8, 0, 0, 0};
      int ey [5] = '{40, 50, 56, 58, 56};
      for (int k = 0; k < 5; k++) begin
         run_req(1'b0, CVSL_FMT_STD, 14'hF, 14'hA, 14'h5, 14'(pq[k]), 4'(lv[k]), 14'h1, 14'h1);
         chk("vol_w", resp_w, ew[k]);
         chk("vol_h", resp_h, eh[k]);
         chk("vol_d", resp_d, ed[k]);
         chk("vol_in", resp_in_surface, 32'(k < 4));
         if (k < 4) chk("vol_addr", resp_addr, 32'h1000 + (ey[k] + 1) * 256 + (ex[k] + 1) * 4);
      end
   endtask
   task automatic t_fetch();
      fetch(32'h2000, 1'b1, 32'hA5A5_0001);
      chk("use_valid", use_valid, 32'h1);
      chk("use_data", use_data, 32'hA5A5_0001);
      fetch(32'h2004, 1'b0, 32'h5A5A_0002);
      chk("use_out", use_valid, 32'h0);
      chk("use_keep", use_data, 32'hA5A5_0001);
      chk("err_none", xlate_err, 32'h0);
      fetch(32'h0002_0040, 1'b0, 32'h0);
      chk("err_set", xlate_err, 32'h1);
      chk("err_addr", xlate_err_addr, 32'h0002_0040);
      fetch(32'h2008, 1'b1, 32'h1);
      chk("err_sticky", xlate_err, 32'h1);
      @(posedge clk);
      xlate_err_clr <= 1'b1;
      @(posedge clk);
      xlate_err_clr <= 1'b0;
      #1;
      chk("err_clr", xlate_err, 32'h0);
      @(posedge clk);
      xlate_err_clr <= 1'b1;
      fetch_valid <= 1'b1;
      fetch_addr <= 32'h0003_0000;
      fetch_in_surface <= 1'b0;
      @(posedge clk);
      xlate_err_clr <= 1'b0;
      fetch_valid <= 1'b0;
      #1;
      chk("err_set_wins", xlate_err, 32'h1);
      chk("err_addr_new", xlate_err_addr, 32'h0003_0000);
   endtask
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      chk("rst_ready", req_ready, 32'h1);
      chk("rst_err", xlate_err, 32'h0);
      t_cube();
      t_align();
      t_volume();
      t_fetch();
      close_out();
   end
   initial begin
      #50000;
      bad_count++;
      close_out();
   end
endmodule
